// ==== hdl/pseq_pkg.sv ====
package pseq_pkg;

   // Clock and time base
   localparam int CLK_HZ = 250_000_000;
   localparam int MS_PER_S = 1000;
   localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;

   // Timing figures, in their own units
   localparam int WAIT_TIMEOUT_S = 20;
   localparam int LONG_PRESS_S = 8;
   localparam int LONG_PRESS_ALT_S = 15;
   localparam int DOWN_TOTAL_MS = 500;
   localparam int WAIT_TIMEOUT_MS = WAIT_TIMEOUT_S * MS_PER_S;
   localparam int LONG_PRESS_MS = LONG_PRESS_S * MS_PER_S;
   localparam int LONG_PRESS_ALT_MS = LONG_PRESS_ALT_S * MS_PER_S;

   // Step delays: code 0..3 selects 2..5 ms
   localparam logic [8:0] DELAY_MIN_MS = 9'h002;
   localparam logic [8:0] DELAY_MAX_MS = 9'h005;
   localparam logic [8:0] DOWN_FACTOR = 9'h00A;

   // Steps
   localparam logic [3:0] FIRST_STEP = 4'h1;
   localparam logic [3:0] BACKUP_LAST_STEP = 4'h2;
   localparam logic [3:0] LAST_STEP = 4'hA;
   localparam logic [3:0] UNASSIGNED = 4'h0;

   // Rail positions in the enable vector
   localparam int RAIL_COUNT = 10;
   localparam int BUCK_ONE = 0;
   localparam int BUCK_TWO = 1;
   localparam int BUCK_THREE = 2;
   localparam int BUCK_BOOST = 3;
   localparam int BACKUP_BUCK_CORE = 4;
   localparam int BACKUP_BUCK_IO = 5;
   localparam int LINEAR_REG_ONE = 6;
   localparam int LOAD_SWITCH_ONE = 7;
   localparam int LOAD_SWITCH_TWO = 8;
   localparam int LOAD_SWITCH_THREE = 9;
   localparam logic [9:0] BACKUP_MASK = 10'h030;
   localparam logic [9:0] EARLY_OFF_MASK = 10'h0CF;
   localparam logic [9:0] LATE_OFF_MASK = 10'h300;
   localparam logic [9:0] RAILS_RESET = 10'h000;

   // Synchronised input positions
   localparam int IN_PB = 0;
   localparam int IN_AC = 1;
   localparam int IN_PEN = 2;
   localparam int IN_MAIN = 3;
   localparam int IN_THERM = 4;
   localparam int IN_LOCK = 5;
   localparam int IN_PGF = 6;
   localparam int IN_COUNT = 7;
   // Button and adapter idle high, so reset release is not a press
   localparam logic [6:0] IN_IDLE = 7'h03;

   typedef enum logic [2:0] {
      ST_OFF, ST_WAIT, ST_ACTIVE, ST_SUSPEND, ST_RECOVERY, ST_DOWN
   } pseq_state_e;

endpackage

// ==== hdl/pseq_sequencer.sv ====
module pseq_sequencer #(
   parameter int TICK_CYCLES = pseq_pkg::TICK_CYCLES,
   parameter int WAIT_TIMEOUT_MS = pseq_pkg::WAIT_TIMEOUT_MS,
   parameter int LONG_PRESS_MS = pseq_pkg::LONG_PRESS_MS,
   parameter int LONG_PRESS_ALT_MS = pseq_pkg::LONG_PRESS_ALT_MS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Pins, asynchronous to clk
   input wire logic push_button_pin,
   input wire logic adapter_detect,
   input wire logic power_enable_pin,
   input wire logic main_supply_present,
   // Fault indications, asynchronous to clk
   input wire logic thermal_trip,
   input wire logic supply_lockout,
   input wire logic power_good_fail,
   // Configuration
   input wire logic [9:0][3:0] step_assign,
   input wire logic [8:0][1:0] step_delay,
   input wire logic down_delay_factor,
   input wire logic backup_seal,
   input wire logic long_press_sel,
   // Software rail enables
   input wire logic sw_enable_wr,
   input wire logic [9:0] sw_enable_data,
   // Status and rail controls
   output logic [9:0] rail_enable,
   output logic [9:0] discharge_enable,
   output pseq_pkg::pseq_state_e power_state,
   output logic seq_busy,
   output logic enable_write_refused
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [6:0] sync1;
      logic [6:0] sync2;
      logic [6:0] prev;
      pseq_pkg::pseq_state_e state;
      pseq_pkg::pseq_state_e target;
      logic up_busy;
      logic [3:0] step;
      logic [8:0] dly;
      logic [17:0] pre;
      logic [14:0] phase;
      logic [13:0] press;
      logic [9:0] rails;
      logic [9:0] dchg;
      logic refused;
   } pseq_regs_s;
   pseq_regs_s r;
   pseq_regs_s next_r;
   // Rails assigned to a step; steps one and two only reach backup rails
   function automatic logic [9:0] rails_at(input logic [9:0][3:0] a,
                                           input logic [3:0] s);
      logic [9:0] m;
      m = '0;
      for (int i = 0; i < pseq_pkg::RAIL_COUNT; i++) begin
         m[i] = (a[i] == s) && (s != pseq_pkg::UNASSIGNED);
      end
      if (s <= pseq_pkg::BACKUP_LAST_STEP) begin
         m = m & pseq_pkg::BACKUP_MASK;
      end
      return m;
   endfunction
   // Delay in ms plus one, so that a free-running tick never cuts it short
   function automatic logic [8:0] delay_ms(input logic [1:0] code,
                                           input logic slow);
      logic [8:0] d;
      d = pseq_pkg::DELAY_MIN_MS + {7'h00, code};
      if (slow) begin
         d = 9'(d * pseq_pkg::DOWN_FACTOR);
      end
      return 9'(d + 9'h001);
   endfunction
   logic [9:0] unseq;
   logic tick, pb, ac, pen, mains, therm, lock, pgf;
   logic pb_fall, ac_fall, fault, blocked, long_hit, busy;
   logic go_up, go_down;
   pseq_pkg::pseq_state_e down_to;
   logic [9:0] m;
   generate
      for (genvar g = 0; g < pseq_pkg::RAIL_COUNT; g++) begin : g_unseq
         assign unseq[g] = step_assign[g] == pseq_pkg::UNASSIGNED;
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      next_r.sync1 = {power_good_fail, supply_lockout, thermal_trip,
                      main_supply_present, power_enable_pin,
                      adapter_detect, push_button_pin};
      next_r.sync2 = r.sync1;
      next_r.prev = r.sync2;
      next_r.refused = 1'b0;
      pb = r.sync2[pseq_pkg::IN_PB];
      ac = r.sync2[pseq_pkg::IN_AC];
      pen = r.sync2[pseq_pkg::IN_PEN];
      mains = r.sync2[pseq_pkg::IN_MAIN];
      therm = r.sync2[pseq_pkg::IN_THERM];
      lock = r.sync2[pseq_pkg::IN_LOCK];
      pgf = r.sync2[pseq_pkg::IN_PGF];
      pb_fall = r.prev[pseq_pkg::IN_PB] & ~pb;
      ac_fall = r.prev[pseq_pkg::IN_AC] & ~ac;
      blocked = therm | lock;
      fault = therm | lock | pgf;
      busy = r.up_busy | (r.state == pseq_pkg::ST_DOWN);
      go_up = 1'b0;
      go_down = 1'b0;
      down_to = pseq_pkg::ST_OFF;
      m = '0;
      // Millisecond time base
      tick = r.pre == 18'(TICK_CYCLES - 1);
      next_r.pre = tick ? '0 : 18'(r.pre + 18'h00001);
      if (tick && r.phase != '1) begin
         next_r.phase = 15'(r.phase + 15'h0001);
      end
      if (pb) begin
         next_r.press = '0;
      end else if (tick && r.press != '1) begin
         next_r.press = 14'(r.press + 14'h0001);
      end
      long_hit = r.press >= (long_press_sel ? 14'(LONG_PRESS_ALT_MS)
                                            : 14'(LONG_PRESS_MS));
      // Software enables apply only while the sequencer is idle
      if (sw_enable_wr) begin
         if (busy) begin
            next_r.refused = 1'b1;
         end else begin
            next_r.rails = sw_enable_data;
            next_r.dchg = r.dchg & ~sw_enable_data;
         end
      end
      // Up sequencer runs alongside the await and active states
      if (r.up_busy) begin
         if (r.dly != '0) begin
            if (tick) begin
               next_r.dly = 9'(r.dly - 9'h001);
            end
         end else begin
            // Already-on rails are enabled again: steps one and two always run
            m = rails_at(step_assign, r.step);
            next_r.rails = next_r.rails | m;
            next_r.dchg = next_r.dchg & ~m;
            if (r.step == pseq_pkg::LAST_STEP) begin
               next_r.up_busy = 1'b0;
            end else begin
               next_r.step = 4'(r.step + 4'h1);
               next_r.dly = delay_ms(step_delay[4'(r.step - 4'h1)], 1'b0);
            end
         end
      end

      ////////////////////////////////////////////////////////////////////
      case (r.state)
         pseq_pkg::ST_OFF, pseq_pkg::ST_RECOVERY: begin
            if (!blocked && (pb_fall || !ac || pen || (mains && !ac))) begin
               go_up = 1'b1;
            end
         end
         pseq_pkg::ST_SUSPEND: begin
            if (fault) begin
               go_down = 1'b1;
               down_to = (backup_seal && blocked) ? pseq_pkg::ST_RECOVERY
                                                  : pseq_pkg::ST_OFF;
            end else if (long_hit) begin
               go_down = 1'b1;
            end else if (pb_fall || ac_fall || pen) begin
               go_up = 1'b1;
            end
         end
         pseq_pkg::ST_WAIT, pseq_pkg::ST_ACTIVE: begin
            if (fault) begin
               go_down = 1'b1;
               down_to = (backup_seal && blocked) ? pseq_pkg::ST_RECOVERY
                                                  : pseq_pkg::ST_OFF;
            end else if (long_hit) begin
               go_down = 1'b1;
            end else if (r.state == pseq_pkg::ST_ACTIVE) begin
               // Adapter detect plays no part here
               if (!pen) begin
                  go_down = 1'b1;
                  down_to = backup_seal ? pseq_pkg::ST_SUSPEND
                                        : pseq_pkg::ST_OFF;
               end
            end else if (pen) begin
               next_r.state = pseq_pkg::ST_ACTIVE;
            end else if (pb && ac &&
                         r.phase >= 15'(WAIT_TIMEOUT_MS)) begin
               go_down = 1'b1;
            end
         end
         pseq_pkg::ST_DOWN: begin
            if (r.step != '0) begin
               if (r.dly != '0) begin
                  if (tick) begin
                     next_r.dly = 9'(r.dly - 9'h001);
                  end
               end else begin
                  m = rails_at(step_assign, r.step);
                  if (backup_seal && r.step <= pseq_pkg::BACKUP_LAST_STEP)
                  begin
                     m = '0;
                  end
                  next_r.rails = next_r.rails & ~m;
                  next_r.dchg = next_r.dchg | m;
                  next_r.step = 4'(r.step - 4'h1);
                  if (r.step != pseq_pkg::FIRST_STEP) begin
                     next_r.dly = delay_ms(step_delay[4'(r.step - 4'h2)],
                                           down_delay_factor);
                  end
               end
            end
            // Fixed end point keeps discharge on well before any restart
            if (r.phase >= 15'(pseq_pkg::DOWN_TOTAL_MS)) begin
               next_r.state = r.target;
               if (r.target != pseq_pkg::ST_SUSPEND) begin
                  m = unseq & pseq_pkg::LATE_OFF_MASK;
                  next_r.rails = next_r.rails & ~m;
                  next_r.dchg = next_r.dchg | m;
               end
            end
         end
         default: begin
            next_r.state = pseq_pkg::ST_OFF;
         end
      endcase
      if (go_up) begin
         next_r.state = pseq_pkg::ST_WAIT;
         next_r.up_busy = 1'b1;
         next_r.step = pseq_pkg::FIRST_STEP;
         next_r.dly = '0;
         next_r.phase = '0;
         next_r.pre = '0;
      end
      if (go_down) begin
         next_r.state = pseq_pkg::ST_DOWN;
         next_r.target = down_to;
         next_r.up_busy = 1'b0;
         next_r.step = pseq_pkg::LAST_STEP;
         next_r.dly = '0;
         next_r.phase = '0;
         next_r.pre = '0;
         // Suspend keeps unsequenced rails as they were in active
         if (down_to != pseq_pkg::ST_SUSPEND) begin
            m = unseq & pseq_pkg::EARLY_OFF_MASK;
            next_r.rails = next_r.rails & ~m;
            next_r.dchg = next_r.dchg | m;
         end
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.sync1 <= pseq_pkg::IN_IDLE;
         r.sync2 <= pseq_pkg::IN_IDLE;
         r.prev <= pseq_pkg::IN_IDLE;
      end else begin
         r <= next_r;
      end
   end
   assign rail_enable = r.rails;
   assign discharge_enable = r.dchg;
   assign power_state = r.state;
   assign seq_busy = r.up_busy | (r.state == pseq_pkg::ST_DOWN);
   assign enable_write_refused = r.refused;
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_write_refused: assert property (sw_enable_wr && seq_busy |=>
      enable_write_refused) else $error("enable write not refused");
   a_active_pen_low: assert property (r.state == pseq_pkg::ST_ACTIVE &&
      !pen && !fault && !long_hit |=> r.state == pseq_pkg::ST_DOWN)
      else $error("active did not power down");
   a_fault_down: assert property (fault && (r.state == pseq_pkg::ST_WAIT ||
      r.state == pseq_pkg::ST_ACTIVE) |=> r.state == pseq_pkg::ST_DOWN)
      else $error("fault did not power down");
   a_down_window: assert property (r.state == pseq_pkg::ST_DOWN |->
      r.phase <= 15'(pseq_pkg::DOWN_TOTAL_MS))
      else $error("down phase overran");
   a_down_exit: assert property (r.state == pseq_pkg::ST_DOWN &&
      r.phase == 15'(pseq_pkg::DOWN_TOTAL_MS) |=> r.state == $past(r.target))
      else $error("final state not entered");
   a_step_delay: assert property (r.up_busy |->
      r.dly <= 9'(pseq_pkg::DELAY_MAX_MS + 9'h001))
      else $error("up delay out of range");
   a_seal_keeps: assert property (r.state == pseq_pkg::ST_DOWN &&
      backup_seal && !sw_enable_wr |=> (r.rails & pseq_pkg::BACKUP_MASK) ==
      ($past(r.rails) & pseq_pkg::BACKUP_MASK))
      else $error("sealed backup rail changed");
   a_early_off: assert property ($rose(r.state == pseq_pkg::ST_DOWN) &&
      r.target != pseq_pkg::ST_SUSPEND |->
      (r.rails & unseq & pseq_pkg::EARLY_OFF_MASK) == '0)
      else $error("unsequenced rail left on");
   a_unseq_up: assert property (r.up_busy && !sw_enable_wr && !go_down &&
      $stable(unseq) |=> (r.rails & unseq) == ($past(r.rails) & unseq))
      else $error("unassigned rail moved");
   a_up_enters: assert property ($rose(r.up_busy) |->
      r.state == pseq_pkg::ST_WAIT && r.step == pseq_pkg::FIRST_STEP)
      else $error("up sequence start wrong");
   c_to_active: cover property (r.state == pseq_pkg::ST_WAIT ##1
      r.state == pseq_pkg::ST_ACTIVE);
   c_to_suspend: cover property (r.state == pseq_pkg::ST_DOWN ##1
      r.state == pseq_pkg::ST_SUSPEND);
   c_to_recovery: cover property (r.state == pseq_pkg::ST_DOWN ##1
      r.state == pseq_pkg::ST_RECOVERY);
   c_refused: cover property (enable_write_refused);

endmodule // pseq_sequencer

// ==== verification/pseq_host_model.sv ====
module pseq_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Requests from the bench
   input wire logic want_on,
   input wire logic pressed,
   input wire logic adapter_on,
   // Pins toward the device
   output logic push_button_pin,
   output logic adapter_detect,
   output logic power_enable_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins come up released so no power-up event is seen at reset release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         push_button_pin <= 1'b1;
         adapter_detect <= 1'b1;
         power_enable_pin <= 1'b0;
      end else begin
         // Host holds enable low only when it wants the rails down
         power_enable_pin <= want_on;
         push_button_pin <= ~pressed;
         adapter_detect <= ~adapter_on;
      end
   end
endmodule // pseq_host_model

// ==== verification/pseq_sequencer_tb.sv ====
module pseq_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0, resetn = 1'b0;
   logic want_on = 1'b0, pressed = 1'b0, adapter_on = 1'b0;
   logic therm = 1'b0, lock = 1'b0, factor = 1'b1, seal = 1'b0;
   logic lp_sel = 1'b0, wr = 1'b0, pg_fail = 1'b0;
   logic [9:0] wdata = 10'h000;
   logic [9:0][3:0] assign_v = {4'hA, 12'h000, 4'h2, 4'h1, 12'h000, 4'h3};
   logic [8:0][1:0] dly_v = 18'h00003;
   wire pb, ac, pen;
   logic [9:0] rails, dis;
   pseq_pkg::pseq_state_e st;
   logic busy, refused;
   int fail_count = 0, check_count = 0;
   int n, d;

   initial forever #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Short counts keep each power-down at 5000 cycles of the run
   pseq_sequencer #(.TICK_CYCLES(10), .WAIT_TIMEOUT_MS(50),
      .LONG_PRESS_MS(30), .LONG_PRESS_ALT_MS(40)) u_pseq_sequencer (
      .clk(clk), .resetn(resetn), .push_button_pin(pb),
      .adapter_detect(ac), .power_enable_pin(pen),
      .main_supply_present(1'b0), .thermal_trip(therm),
      .supply_lockout(lock), .power_good_fail(pg_fail),
      .step_assign(assign_v), .step_delay(dly_v),
      .down_delay_factor(factor), .backup_seal(seal),
      .long_press_sel(lp_sel), .sw_enable_wr(wr),
      .sw_enable_data(wdata), .rail_enable(rails),
      .discharge_enable(dis), .power_state(st), .seq_busy(busy),
      .enable_write_refused(refused));

   pseq_host_model u_pseq_host_model (
      .clk(clk), .resetn(resetn), .want_on(want_on), .pressed(pressed),
      .adapter_on(adapter_on), .push_button_pin(pb),
      .adapter_detect(ac), .power_enable_pin(pen));

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [9:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_st(input pseq_pkg::pseq_state_e s, input int lim,
                          output int cnt);
      cnt = 0;
      while (st !== s) begin
         @(posedge clk);
         #1;
         cnt++;
         if (cnt > lim) begin
            chk("state_wait", {7'h00, st}, {7'h00, s});
            complete_run();
         end
      end
   endtask

   task automatic wait_idle();
      int k;
      for (k = 0; k < 1000 && busy !== 1'b0; k++) begin
         @(posedge clk);
         #1;
      end
      chk("busy_end", {9'h000, busy}, 10'h000);
   endtask

   // Write pulse lasts one cycle; its answer is settled when this returns
   task automatic sw_write(input logic [9:0] dv);
      @(posedge clk);
      wr <= 1'b1;
      wdata <= dv;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic go_active();
      want_on <= 1'b1;
      wait_st(pseq_pkg::ST_ACTIVE, 20, n);
      wait_idle();
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk("rst_rails", rails, 10'h000);
      chk("rst_state", {7'h00, st}, 10'h000);
      $display("test reset done");

      @(posedge clk);
      lock <= 1'b1;
      want_on <= 1'b1;
      repeat (20) @(posedge clk);
      #1;
      chk("lockout_off", {7'h00, st}, 10'h000);
      lock <= 1'b0;
      wait_st(pseq_pkg::ST_WAIT, 20, n);
      chk("up_busy", {9'h000, busy}, 10'h001);
      d = 0;
      for (int k = 0; k < 200 && rails[5] !== 1'b1; k++) begin
         @(posedge clk);
         #1;
         if (rails[4] === 1'b1 && rails[5] !== 1'b1) d++;
      end
      chk("step_gap", {9'h000, d >= 48 && d <= 62}, 10'h001);
      chk("step3_later", {9'h000, rails[0]}, 10'h000);
      sw_write(10'h3FF);
      chk("refuse", {9'h000, refused}, 10'h001);
      chk("refuse_rail", {9'h000, rails[6]}, 10'h000);
      wait_idle();
      chk("up_rails", rails, 10'h231);
      adapter_on <= 1'b1;
      repeat (10) @(posedge clk);
      adapter_on <= 1'b0;
      #1;
      chk("active", {7'h00, st}, 10'h002);
      // Writes only once the sequencer is idle
      sw_write(10'h371);
      chk("sw_rails", rails, 10'h371);
      $display("test power-up done");

      want_on <= 1'b0;
      wait_st(pseq_pkg::ST_DOWN, 10, n);
      @(posedge clk);
      #1;
      chk("first_drop", rails & 10'h340, 10'h100);
      chk("discharge", {9'h000, dis[9]}, 10'h001);
      repeat (1000) @(posedge clk);
      #1;
      chk("factor", {9'h000, rails[0]}, 10'h001);
      wait_st(pseq_pkg::ST_OFF, 5100, n);
      // The trigger lies 1001 cycles before this wait began
      chk("down_time", {9'h000, n + 1001 >= 4994 && n + 1001 <= 5004},
          10'h001);
      chk("off_rails", rails, 10'h000);
      $display("test power-down off done");

      sw_write(10'h040);
      seal <= 1'b1;
      go_active();
      chk("up2_rails", rails, 10'h271);
      want_on <= 1'b0;
      wait_st(pseq_pkg::ST_SUSPEND, 5100, n);
      chk("susp_rails", rails, 10'h070);
      $display("test suspend done");

      adapter_on <= 1'b1;
      wait_st(pseq_pkg::ST_WAIT, 20, n);
      adapter_on <= 1'b0;
      wait_st(pseq_pkg::ST_DOWN, 700, n);
      chk("timeout", {9'h000, n >= 480 && n <= 510}, 10'h001);
      wait_st(pseq_pkg::ST_OFF, 5100, n);
      chk("tmo_rails", rails, 10'h030);
      $display("test await timeout done");

      for (int s = 0; s < 2; s++) begin
         lp_sel <= s[0];
         pressed <= 1'b1;
         wait_st(pseq_pkg::ST_WAIT, 20, n);
         wait_st(pseq_pkg::ST_DOWN, 500, n);
         d = (s == 0) ? 300 : 400;
         chk("long_press", {9'h000, n >= d - 12 && n <= d + 2},
             10'h001);
         pressed <= 1'b0;
         wait_st(pseq_pkg::ST_OFF, 5100, n);
      end
      $display("test long press done");

      go_active();
      therm <= 1'b1;
      wait_st(pseq_pkg::ST_DOWN, 10, n);
      therm <= 1'b0;
      wait_st(pseq_pkg::ST_RECOVERY, 5100, n);
      chk("rec_rails", rails, 10'h030);
      $display("test fault done");

      // Power-good fault ends in off even with the seal set
      go_active();
      factor <= 1'b0;
      pg_fail <= 1'b1;
      wait_st(pseq_pkg::ST_DOWN, 10, n);
      pg_fail <= 1'b0;
      want_on <= 1'b0;
      repeat (300) @(posedge clk);
      #1;
      chk("fast_down", {9'h000, rails[0]}, 10'h000);
      wait_st(pseq_pkg::ST_OFF, 5100, n);
      chk("pgf_rails", rails, 10'h030);
      $display("test power-good fault done");
      complete_run();
   end
endmodule // pseq_sequencer_tb
